// [pkg/jifr_cfg.svh]
// Offsets, field positions, reset values and bit counts of the response framer
`ifndef JIFR_CFG_SVH
`define JIFR_CFG_SVH

// Register offsets on the plain register port
`define JIFR_OFS_CTRL2      4'h0
`define JIFR_OFS_DATA       4'h1
`define JIFR_OFS_VECTOR     4'h2
`define JIFR_OFS_STATUS     4'h3

// Control register two field positions
`define JIFR_BIT_TX_END_OF_DATA       0
`define JIFR_BIT_NBFS       1
`define JIFR_BIT_MNOCRC     2
`define JIFR_BIT_MCRC       3
`define JIFR_BIT_SINGLE     4

// Status register field positions
`define JIFR_BIT_ST_LOST    0
`define JIFR_BIT_ST_TX_DATA_EMPTY_FLAG    1
`define JIFR_BIT_ST_ERR     2
`define JIFR_BIT_ST_BUSY    3

// Reset values
`define JIFR_CTRL2_RST      8'h00
`define JIFR_DATA_RST       8'h00

// State vector codes, steps of four
`define JIFR_VEC_NONE       8'h00
`define JIFR_VEC_RXEOF      8'h04
`define JIFR_VEC_RX_RESP_BYTE_FLAG      8'h08
`define JIFR_VEC_RX_DATA_FULL_FLAG       8'h0C
`define JIFR_VEC_TX_DATA_EMPTY_FLAG       8'h10
`define JIFR_VEC_LOST       8'h14
`define JIFR_VEC_CRCERR     8'h18
`define JIFR_VEC_SYMERR     8'h1C
`define JIFR_VEC_WAKE       8'h20

// Protocol limits and bit counts
`define JIFR_MAX_MSG_BYTES  12
`define JIFR_BYTE_BITS      8
`define JIFR_LAST_TWO_BIT   6
`define JIFR_EXTRA_ONES     2

`endif

// [pkg/jifr_pkg.sv]
// Types shared by the in-frame response transmit control
package jifr_pkg;

  typedef enum logic [1:0] {
    JIFR_MODE_NONE,
    JIFR_MODE_SINGLE,
    JIFR_MODE_MCRC,
    JIFR_MODE_MNOCRC
  } jifr_mode_t;

  // Requests to the symbol layer
  typedef struct packed {
    logic       send_nb;
    logic       nb_value;
    logic       send_byte;
    logic [7:0] byte_val;
    logic       send_crc;
    logic       send_eod;
    logic       send_ones;
  } jifr_sym_req_t;

  // Events from the symbol layer and receiver
  typedef struct packed {
    logic       eod_rx;
    logic       crc_ok;
    logic       nb_done;
    logic       byte_done;
    logic       crc_done;
    logic       eod_done;
    logic       ones_done;
    logic       arb_lost;
    logic [2:0] arb_bit;
    logic       bus_error;
    logic       ifr_winner_done;
    logic [4:0] frame_bytes;
  } jifr_sym_evt_t;

  // Interrupt sources from the rest of the controller; wake, sym_err and crc_err rank above lost, the rest below tx_data_empty_flag
  typedef struct packed {
    logic wake;
    logic sym_err;
    logic crc_err;
    logic rx_data_full_flag;
    logic rx_resp_byte_flag;
    logic rxeof;
  } jifr_src_t;

endpackage

// [verification/jifr_sym_model.sv]
// Symbol layer and bus model answering each request
`timescale 1ns/100ps
`default_nettype none

module jifr_sym_model (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire jifr_pkg::jifr_sym_req_t req,
  input  wire logic                    slow,
  input  wire logic                    lose,
  input  wire logic [2:0]              lose_bit,
  output jifr_pkg::jifr_sym_evt_t      evt
);
  import jifr_pkg::*;
  logic [4:0] kind;
  logic [4:0] kind_reg;
  logic       lose_reg;
  logic [3:0] cnt_reg;

  assign kind = {req.send_nb, req.send_byte, req.send_crc,
                 req.send_eod, req.send_ones};

  // One done or one loss per request, after a bus-time delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kind_reg <= '0;
      lose_reg <= 1'b0;
      cnt_reg <= '0;
      evt <= '0;
    end else begin
      evt <= '0;
      evt.arb_bit <= lose_bit;
      if (|kind) begin
        kind_reg <= kind;
        lose_reg <= lose & req.send_byte;
        cnt_reg <= slow ? 4'hC : 4'h1;
      end else if (cnt_reg == 4'h1) begin
        cnt_reg <= '0;
        evt.nb_done <= kind_reg[4];
        evt.byte_done <= kind_reg[3] & !lose_reg;
        evt.arb_lost <= lose_reg;
        evt.crc_done <= kind_reg[2];
        evt.eod_done <= kind_reg[1];
        evt.ones_done <= kind_reg[0];
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// [verification/jifr_tx_ctrl_assertions.sv]
// Port relations of the response transmit control
`timescale 1ns/100ps
`default_nettype none

module jifr_tx_ctrl_chk #(
  parameter int MAX_BYTES = 12
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [3:0]              addr,
  input wire logic [7:0]              wdata,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [7:0]              rdata,
  input wire jifr_pkg::jifr_sym_evt_t evt,
  input wire jifr_pkg::jifr_src_t     src,
  input wire jifr_pkg::jifr_sym_req_t sym_req,
  input wire logic [7:0]              vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_rdata_rest: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_nb_cause: assert property (sym_req.send_nb |-> $past(evt.eod_rx))
    else $error("normalization bit without received end of data");
  a_byte_follow: assert property (evt.nb_done |=> sym_req.send_byte)
    else $error("no byte after normalization bit");
  a_eod_after_crc: assert property (evt.crc_done |=> sym_req.send_eod)
    else $error("no end of data after check byte");
  a_crc_cause: assert property (sym_req.send_crc |-> $past(evt.byte_done))
    else $error("check byte not after a finished byte");
  a_nb_once: assert property (
    sym_req.send_nb |=> !sym_req.send_nb ##1 !sym_req.send_nb)
    else $error("normalization bit repeated");
  a_vec_steps: assert property (vector[1:0] == 2'b00 && vector <= 8'h20)
    else $error("vector off its steps");
  a_wake_first: assert property (src.wake |=> vector == 8'h20)
    else $error("wakeup not shown first");

  // Main transfers seen
  c_crc: cover property (sym_req.send_crc);
  c_ones: cover property (sym_req.send_ones);
  c_eod: cover property (sym_req.send_eod);
endmodule

bind jifr_tx_ctrl jifr_tx_ctrl_chk #(.MAX_BYTES(MAX_BYTES)) chk_i (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .evt(evt), .src(src), .sym_req(sym_req),
  .vector(vector));

`default_nettype wire

// [verification/test_j1850_in_frame_response_tx.sv]
// Self-checking bench of the response transmit control
`timescale 1ns/100ps
`default_nettype none
`include "jifr_cfg.svh"

`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); \
  end \
end

module test_j1850_in_frame_response_tx;
  import jifr_pkg::*;
  localparam logic [3:0] C2 = `JIFR_OFS_CTRL2;
  localparam logic [3:0] DR = `JIFR_OFS_DATA;
  localparam logic [3:0] VR = `JIFR_OFS_VECTOR;
  localparam logic [3:0] ST = `JIFR_OFS_STATUS;
  logic clk, rst, wr, rd, slow, lose;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, vector;
  logic [2:0] lose_bit;
  jifr_src_t src;
  jifr_sym_evt_t tb_evt, mdl_evt, evt;
  jifr_sym_req_t sym_req;
  int n_errors, n_compared;

  assign evt = tb_evt | mdl_evt;

  jifr_tx_ctrl jifr_tx_ctrl_i (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .evt(evt),
    .src(src), .sym_req(sym_req), .vector(vector));
  jifr_sym_model jifr_sym_model_i (.clk(clk), .rst(rst), .req(sym_req),
    .slow(slow), .lose(lose), .lose_bit(lose_bit), .evt(mdl_evt));

  task automatic give_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Register port cycles
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    `CHK("rdata", e, rdata)
  endtask

  // Received end of data from the far node
  task automatic eod;
    tb_evt.eod_rx <= 1'b1;
    @(posedge clk);
    tb_evt.eod_rx <= 1'b0;
  endtask

  // Next request pulse must be of kind k
  task automatic wait_req(input logic [4:0] k, input logic [7:0] b);
    int i;
    logic [4:0] s;
    i = 0;
    s = '0;
    while (s == 5'h00 && i < 400) begin
      @(posedge clk);
      s = {sym_req.send_nb, sym_req.send_byte, sym_req.send_crc,
           sym_req.send_eod, sym_req.send_ones};
      i++;
    end
    `CHK("request", k, s)
    if (k[3]) `CHK("byte", b, sym_req.byte_val)
  endtask

  task automatic t_vector;
    src.rxeof <= 1'b1;
    repeat (2) @(posedge clk);
    rreg(VR, 8'h04);
    src.wake <= 1'b1;
    repeat (2) @(posedge clk);
    rreg(VR, 8'h20);
    src <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_late_set;
    logic [7:0] code [3];
    code = '{8'h10, 8'h08, 8'h04};
    tb_evt.frame_bytes <= 5'h03;
    eod();
    foreach (code[i]) begin
      wreg(C2, code[i]);
      rreg(C2, 8'h00);
    end
    tb_evt.frame_bytes <= 5'h00;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_single;
    wreg(DR, 8'hA5);
    wreg(C2, 8'h10);
    eod();
    wait_req(5'h10, 8'h00);
    `CHK("nb", 1'b0, sym_req.nb_value)
    wait_req(5'h08, 8'hA5);
    repeat (20) @(posedge clk);
    rreg(C2, 8'h00);
  endtask

  task automatic t_single_lost;
    logic [4:0] seen;
    wreg(DR, 8'h5A);
    wreg(C2, 8'h10);
    lose <= 1'b1;
    lose_bit <= 3'h7;
    eod();
    wait_req(5'h10, 8'h00);
    wait_req(5'h08, 8'h5A);
    lose <= 1'b0;
    seen = '0;
    repeat (30) begin
      @(posedge clk);
      seen |= {sym_req.send_nb, sym_req.send_byte, sym_req.send_crc,
               sym_req.send_eod, sym_req.send_ones};
    end
    `CHK("no ones", 5'h00, seen)
    tb_evt.ifr_winner_done <= 1'b1;
    @(posedge clk);
    tb_evt.ifr_winner_done <= 1'b0;
    wait_req(5'h08, 8'h5A);
    repeat (20) @(posedge clk);
    rreg(C2, 8'h00);
  endtask

  task automatic t_multi_crc;
    wreg(DR, 8'h11);
    wreg(C2, 8'h0C);
    rreg(C2, 8'h0C);
    eod();
    wait_req(5'h10, 8'h00);
    `CHK("nb", 1'b1, sym_req.nb_value)
    repeat (2) @(posedge clk);
    rreg(VR, 8'h10);
    wreg(DR, 8'h22);
    wreg(C2, 8'h0D);
    wait_req(5'h08, 8'h11);
    wait_req(5'h08, 8'h22);
    wait_req(5'h04, 8'h00);
    wait_req(5'h02, 8'h00);
    repeat (20) @(posedge clk);
    rreg(C2, 8'h00);
  endtask

  task automatic t_multi_lost;
    wreg(DR, 8'h33);
    wreg(C2, 8'h08);
    lose <= 1'b1;
    lose_bit <= 3'h6;
    eod();
    wait_req(5'h10, 8'h00);
    wait_req(5'h08, 8'h33);
    lose <= 1'b0;
    wait_req(5'h01, 8'h00);
    repeat (20) @(posedge clk);
    rreg(C2, 8'h00);
    rreg(VR, 8'h14);
  endtask

  task automatic t_multi_nocrc;
    wreg(DR, 8'h44);
    wreg(C2, 8'h06);
    eod();
    wait_req(5'h10, 8'h00);
    `CHK("nb", 1'b1, sym_req.nb_value)
    wreg(C2, 8'h07);
    wait_req(5'h08, 8'h44);
    wait_req(5'h02, 8'h00);
    repeat (20) @(posedge clk);
    rreg(C2, 8'h02);
  endtask

  // No byte written after transmit-empty: underrun ends the response
  task automatic t_underrun;
    wreg(DR, 8'h55);
    wreg(C2, 8'h0A);
    eod();
    wait_req(5'h10, 8'h00);
    `CHK("nb", 1'b0, sym_req.nb_value)
    wait_req(5'h08, 8'h55);
    wait_req(5'h01, 8'h00);
    repeat (20) @(posedge clk);
    rreg(C2, 8'h02);
    rreg(ST, 8'h04);
  endtask

  // Frame bytes plus response bytes reach the message maximum
  task automatic t_length;
    tb_evt.frame_bytes <= 5'h0B;
    wreg(DR, 8'h77);
    wreg(C2, 8'h04);
    eod();
    wait_req(5'h10, 8'h00);
    wreg(DR, 8'h78);
    wait_req(5'h08, 8'h77);
    wait_req(5'h01, 8'h00);
    tb_evt.frame_bytes <= 5'h00;
    repeat (20) @(posedge clk);
    rreg(C2, 8'h00);
  endtask

  // Bus error during a single-byte response
  task automatic t_bus_err;
    wreg(DR, 8'h66);
    wreg(C2, 8'h10);
    eod();
    wait_req(5'h10, 8'h00);
    wait_req(5'h08, 8'h66);
    tb_evt.bus_error <= 1'b1;
    @(posedge clk);
    tb_evt.bus_error <= 1'b0;
    repeat (20) @(posedge clk);
    rreg(C2, 8'h00);
    rreg(ST, 8'h04);
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    {wr, rd, lose, addr, wdata, lose_bit} = '0;
    src = '0;
    tb_evt = '0;
    tb_evt.crc_ok = 1'b1;
    slow = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(C2, 8'h00);
    rreg(VR, 8'h00);
    rreg(4'hF, 8'h00);
    t_vector();
    t_late_set();
    t_single();
    t_single_lost();
    t_multi_crc();
    t_multi_lost();
    t_multi_nocrc();
    t_underrun();
    t_length();
    t_bus_err();
    give_verdict();
  end
endmodule

`default_nettype wire

// [verilog/jifr_tx_ctrl.sv]
// In-frame response transmit control with its register port
`timescale 1ns/100ps
`default_nettype none
`include "jifr_cfg.svh"

module jifr_tx_ctrl #(
  parameter int MAX_BYTES = `JIFR_MAX_MSG_BYTES
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [3:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [7:0]                  rdata,
  input  wire jifr_pkg::jifr_sym_evt_t evt,
  input  wire jifr_pkg::jifr_src_t    src,
  output jifr_pkg::jifr_sym_req_t     sym_req,
  output logic [7:0]                  vector
);
  import jifr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_NB,
    ST_BYTE,
    ST_WAIT_WIN,
    ST_CRC,
    ST_EOD,
    ST_ONES
  } jifr_state_t;

  typedef struct packed {
    jifr_state_t    st;
    logic [7:0]     ctrl;
    logic [7:0]     data;
    logic           data_full;
    logic [7:0]     shift;
    logic           tx_data_empty_flag;
    logic           vec_read;
    logic           lost;
    logic           err;
    logic           eod_block;
    logic [4:0]     count;
    logic           last_loaded;
    logic [7:0]     rdata;
    jifr_sym_req_t  req;
  } jifr_regs_t;

  jifr_regs_t s_reg;
  jifr_regs_t s_next;
  logic [7:0] vec_reg;
  jifr_mode_t mode;
  logic       tx_end_of_data;
  logic       wr_ctrl;
  logic       wr_data;

  ////////////////////////////////////////////////////////////////////////
  // Vector encoder
  jifr_vec_enc u_vec (
    .clk     (clk),
    .rst     (rst),
    .src     (src),
    .tx_data_empty_flag    (s_reg.tx_data_empty_flag),
    .lost    (s_reg.lost),
    .vec_reg (vec_reg)
  );

  // Priority decode of stored request bits
  always_comb begin
    if (s_reg.ctrl[`JIFR_BIT_SINGLE])
      mode = JIFR_MODE_SINGLE;
    else if (s_reg.ctrl[`JIFR_BIT_MCRC])
      mode = JIFR_MODE_MCRC;
    else if (s_reg.ctrl[`JIFR_BIT_MNOCRC])
      mode = JIFR_MODE_MNOCRC;
    else
      mode = JIFR_MODE_NONE;
  end

  assign tx_end_of_data    = s_reg.ctrl[`JIFR_BIT_TX_END_OF_DATA];
  assign wr_ctrl = wr && (addr == `JIFR_OFS_CTRL2);
  assign wr_data = wr && (addr == `JIFR_OFS_DATA);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.req = '0;
    s_next.rdata = 8'h00;

    // Register reads
    if (rd) begin
      unique case (addr)
        `JIFR_OFS_CTRL2:  s_next.rdata = s_reg.ctrl;
        `JIFR_OFS_DATA:   s_next.rdata = s_reg.data;
        `JIFR_OFS_VECTOR: s_next.rdata = vec_reg;
        `JIFR_OFS_STATUS: s_next.rdata = {4'h0,
                                          s_reg.st != ST_IDLE,
                                          s_reg.err,
                                          s_reg.tx_data_empty_flag,
                                          s_reg.lost};
        default:          s_next.rdata = 8'h00;
      endcase
      if (addr == `JIFR_OFS_VECTOR) begin
        s_next.vec_read = s_reg.tx_data_empty_flag;
        s_next.lost = 1'b0;
      end
    end

    // Register writes
    if (wr_ctrl) begin
      s_next.ctrl = wdata;
      // Request bits cannot be armed once EOD has already passed
      if (s_reg.eod_block) begin
        s_next.ctrl[`JIFR_BIT_SINGLE] = wdata[`JIFR_BIT_SINGLE]
                                        & s_reg.ctrl[`JIFR_BIT_SINGLE];
        s_next.ctrl[`JIFR_BIT_MCRC]   = wdata[`JIFR_BIT_MCRC]
                                        & s_reg.ctrl[`JIFR_BIT_MCRC];
        s_next.ctrl[`JIFR_BIT_MNOCRC] = wdata[`JIFR_BIT_MNOCRC]
                                        & s_reg.ctrl[`JIFR_BIT_MNOCRC];
      end
      if (wdata[`JIFR_BIT_TX_END_OF_DATA]) begin
        s_next.tx_data_empty_flag = 1'b0;
        s_next.vec_read = 1'b0;
      end
    end
    if (wr_data) begin
      s_next.data = wdata;
      s_next.data_full = 1'b1;
      if (s_reg.vec_read) begin
        s_next.tx_data_empty_flag = 1'b0;
        s_next.vec_read = 1'b0;
      end
    end

    // Window after a received EOD in which arming is refused
    if (evt.eod_rx)
      s_next.eod_block = 1'b1;
    else if (s_reg.st == ST_IDLE && evt.frame_bytes == 5'd0)
      s_next.eod_block = 1'b0;

    unique case (s_reg.st)
      ST_IDLE: begin
        s_next.count = evt.frame_bytes;
        s_next.last_loaded = 1'b0;
        if (evt.eod_rx && evt.crc_ok && mode != JIFR_MODE_NONE) begin
          s_next.st = ST_NB;
          s_next.req.send_nb = 1'b1;
          s_next.req.nb_value = (mode == JIFR_MODE_MCRC)
                                ^ s_reg.ctrl[`JIFR_BIT_NBFS];
          s_next.shift = s_reg.data;
          s_next.data_full = 1'b0;
          s_next.err = 1'b0;
          if (mode != JIFR_MODE_SINGLE && !tx_end_of_data)
            s_next.tx_data_empty_flag = 1'b1;
          if (tx_end_of_data)
            s_next.last_loaded = 1'b1;
        end
      end
      ST_NB: begin
        if (evt.nb_done) begin
          s_next.st = ST_BYTE;
          s_next.req.send_byte = 1'b1;
          s_next.req.byte_val = s_reg.shift;
          s_next.count = s_reg.count + 5'd1;
        end
      end
      ST_BYTE: begin
        if (evt.arb_lost) begin
          if (mode == JIFR_MODE_SINGLE) begin
            s_next.st = ST_WAIT_WIN;
          end else begin
            s_next.lost = 1'b1;
            s_next.ctrl[`JIFR_BIT_MCRC] = 1'b0;
            s_next.ctrl[`JIFR_BIT_MNOCRC] = 1'b0;
            s_next.tx_data_empty_flag = 1'b0;
            if (evt.arb_bit >= 3'(`JIFR_LAST_TWO_BIT)) begin
              s_next.st = ST_ONES;
              s_next.req.send_ones = 1'b1;
            end else begin
              s_next.st = ST_IDLE;
            end
          end
        end else if (evt.byte_done) begin
          if (mode == JIFR_MODE_SINGLE) begin
            s_next.ctrl[`JIFR_BIT_SINGLE] = 1'b0;
            s_next.st = ST_IDLE;
          end else if (tx_end_of_data && !s_reg.data_full
                       || s_reg.last_loaded) begin
            // final byte gone, finish the response
            if (mode == JIFR_MODE_MCRC) begin
              s_next.st = ST_CRC;
              s_next.req.send_crc = 1'b1;
            end else begin
              s_next.st = ST_EOD;
              s_next.req.send_eod = 1'b1;
            end
          end else if (s_reg.data_full
                       && s_reg.count < 5'(MAX_BYTES)) begin
            s_next.shift = s_reg.data;
            s_next.data_full = 1'b0;
            s_next.count = s_reg.count + 5'd1;
            s_next.req.send_byte = 1'b1;
            s_next.req.byte_val = s_reg.data;
            if (tx_end_of_data)
              s_next.last_loaded = 1'b1;
            else
              s_next.tx_data_empty_flag = 1'b1;
          end else begin
            // Underrun or length overflow ends the response
            s_next.err = 1'b1;
            s_next.ctrl[`JIFR_BIT_MCRC] = 1'b0;
            s_next.ctrl[`JIFR_BIT_MNOCRC] = 1'b0;
            s_next.tx_data_empty_flag = 1'b0;
            s_next.st = ST_ONES;
            s_next.req.send_ones = 1'b1;
          end
        end
      end
      ST_WAIT_WIN: begin
        if (evt.ifr_winner_done) begin
          s_next.st = ST_BYTE;
          s_next.req.send_byte = 1'b1;
          s_next.req.byte_val = s_reg.shift;
        end
      end
      ST_CRC: begin
        if (evt.crc_done) begin
          s_next.st = ST_EOD;
          s_next.req.send_eod = 1'b1;
        end
      end
      ST_EOD: begin
        if (evt.eod_done) begin
          s_next.ctrl[`JIFR_BIT_MCRC] = 1'b0;
          s_next.ctrl[`JIFR_BIT_MNOCRC] = 1'b0;
          s_next.ctrl[`JIFR_BIT_TX_END_OF_DATA] = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      ST_ONES: begin
        if (evt.ones_done)
          s_next.st = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase

    // End bit set during a single-byte response ends it in any state but idle, first attempt included
    if (mode == JIFR_MODE_SINGLE && tx_end_of_data && s_reg.st != ST_IDLE) begin
      s_next.ctrl[`JIFR_BIT_SINGLE] = 1'b0;
      s_next.st = ST_IDLE;
    end

    // Bus error aborts any response and clears all requests
    if (evt.bus_error) begin
      s_next.ctrl[`JIFR_BIT_SINGLE] = 1'b0;
      s_next.ctrl[`JIFR_BIT_MCRC] = 1'b0;
      s_next.ctrl[`JIFR_BIT_MNOCRC] = 1'b0;
      s_next.ctrl[`JIFR_BIT_TX_END_OF_DATA] = 1'b0;
      s_next.err = 1'b1;
      s_next.tx_data_empty_flag = 1'b0;
      s_next.st = ST_IDLE;
      s_next.req = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.ctrl <= `JIFR_CTRL2_RST;
      s_reg.data <= `JIFR_DATA_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign rdata   = s_reg.rdata;
  assign sym_req = s_reg.req;
  assign vector  = vec_reg;

endmodule
`default_nettype wire

// [verilog/jifr_vec_enc.sv]
// Priority encoder of pending sources into the state vector
`timescale 1ns/100ps
`default_nettype none
`include "jifr_cfg.svh"

module jifr_vec_enc (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire jifr_pkg::jifr_src_t src,
  input  wire logic                tx_data_empty_flag,
  input  wire logic                lost,
  output logic [7:0]               vec_reg
);
  import jifr_pkg::*;

  logic [7:0] vec_next;

  ////////////////////////////////////////////////////////////////////////
  // Highest pending source wins
  always_comb begin
    if (src.wake)
      vec_next = `JIFR_VEC_WAKE;
    else if (src.sym_err)
      vec_next = `JIFR_VEC_SYMERR;
    else if (src.crc_err)
      vec_next = `JIFR_VEC_CRCERR;
    else if (lost)
      vec_next = `JIFR_VEC_LOST;
    else if (tx_data_empty_flag)
      vec_next = `JIFR_VEC_TX_DATA_EMPTY_FLAG;
    else if (src.rx_data_full_flag)
      vec_next = `JIFR_VEC_RX_DATA_FULL_FLAG;
    else if (src.rx_resp_byte_flag)
      vec_next = `JIFR_VEC_RX_RESP_BYTE_FLAG;
    else if (src.rxeof)
      vec_next = `JIFR_VEC_RXEOF;
    else
      vec_next = `JIFR_VEC_NONE;
  end

  // Registered vector
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      vec_reg <= `JIFR_VEC_NONE;
    else
      vec_reg <= vec_next;
  end

endmodule
`default_nettype wire
